/* rtl/ebc_ctrl.sv */
`timescale 1ns/10ps
`include "ebc_regs.svh"
// Function
// - drive 24-bit external address and 16-bit data, 8-bit devices also
// - 256 Mbyte window holds eight chip selects of up to 16 Mbytes, twice over
// - external side runs on its own clock, at most 66.66 MHz
// - each chip select has its own style and timing
// - chip select 0 boots slow, width from address bit 0 strap
// - chip selects 1 to 7 stay unusable until programmed
// - address pins are inputs in reset, latched then driven after
// - address 23:0 driven with an address latch strobe in each access
// - address phase 1 or 2 clocks, plus 0 to 3 extension clocks
// - data strobe style turns write strobe to strobe, read to direction
// - shared wait stretches reads for strobe and data strobe styles
// - host-port chip selects 4 to 7 follow own ready, ignore wait
// - only chip selects 4 to 7 may use host-port style
// - export strap, map, interrupt and bus host settings to the chip
// - address bits 26:24 pick the chip select, bit 27 aliases
// - low 24 system address bits go straight to the pins
// - region size is 512 bytes times two to the size field
// - word accesses to narrow devices are reads, assembled into 32 bits
module ebc_ctrl (
  // clocks and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ext_bus_clock_in,
  // system request
  input wire logic sys_req_valid,
  output logic sys_req_ready,
  input wire logic [27:0] sys_req_addr,
  input wire logic sys_req_write,
  input wire logic [1:0] sys_req_size,
  input wire logic [31:0] sys_req_wdata,
  // system response
  output logic sys_resp_valid,
  output logic [31:0] sys_resp_rdata,
  output logic sys_resp_err,
  // chip select configuration, one, two or four bits per select
  input wire logic [7:0] cs_programmed,
  input wire logic [15:0] cs_style,
  input wire logic [15:0] cs_addr_phase_extend,
  input wire logic [31:0] cs_size,
  input wire logic [31:0] cs_strobe_cycles,
  input wire logic [7:0] cs_mux,
  input wire logic [7:0] cs_width8,
  // exported configuration
  input wire logic low_map_wr,
  input wire logic low_map_val,
  input wire logic [1:0] sw_irq_in,
  output logic [23:0] cfg_strap_word,
  output logic cfg_strap_valid,
  output logic cfg_low_map,
  output logic cfg_pci_host,
  output logic cfg_pci_arbiter,
  output logic [1:0] cfg_sw_irq,
  // external pins
  input wire logic [23:0] ext_addr_in,
  output logic [23:0] ext_addr_out,
  output logic ext_addr_oe,
  input wire logic [15:0] ext_data_in,
  output logic [15:0] ext_data_out,
  output logic ext_data_oe,
  output logic addr_latch_strobe,
  output logic [7:0] ext_cs_n,
  output logic write_strobe_n,
  output logic read_strobe_n,
  input wire logic shared_wait_n,
  input wire logic [3:0] hostport_ready_n
);
  ebc_evt_if req_ev ();
  ebc_evt_if ack_ev ();
  ebc_evt_if strap_ev ();

  ebc_pkg::ebc_cstate_t cst_r;
  ebc_pkg::ebc_req_t q_r;
  logic req_tgl_r;
  logic err_r;
  logic [31:0] rdata_r;
  logic [23:0] strap_core_r;
  logic strap_ok_r;
  logic low_map_r;
  logic [1:0] sw_irq_r;
  // crossing words: written in the external domain, read here once settled
  logic [23:0] strap_r;
  logic [31:0] acc_r;

  // per chip select effective settings
  logic [1:0] eff_sty [8];
  logic [1:0] eff_ext [8];
  logic [3:0] eff_size [8];
  logic [3:0] eff_strb [8];
  logic eff_mux [8];
  logic eff_w8 [8];
  logic eff_ok [8];

  genvar gi;
  generate
    for (gi = 0; gi < `EBC_NCS; gi++) begin : g_cs
      wire dflt = (gi == 0) && !cs_programmed[0];
      wire [1:0] sty_raw = cs_style[2*gi +: 2];
      wire hp_bad = (gi < 4) && (sty_raw == ebc_pkg::EBC_STY_HPORT);
      // low selects fall back to read/write strobes
      assign eff_sty[gi] = (dflt || hp_bad) ? ebc_pkg::EBC_STY_RDWR :
                           sty_raw;
      assign eff_ext[gi] = dflt ? `EBC_CS0_EXT_RST :
                           cs_addr_phase_extend[2*gi +: 2];
      assign eff_size[gi] = dflt ? `EBC_CS0_SIZE_RST : cs_size[4*gi +: 4];
      assign eff_strb[gi] = dflt ? `EBC_CS0_STRB_RST :
                            cs_strobe_cycles[4*gi +: 4];
      assign eff_mux[gi] = dflt ? `EBC_CS0_MUX_RST : cs_mux[gi];
      // boot width: strap high means 16-bit
      assign eff_w8[gi] = dflt ? !strap_core_r[`EBC_STRAP_W16_BIT] :
                          cs_width8[gi];
      assign eff_ok[gi] = (gi == 0) || cs_programmed[gi];
    end
  endgenerate

  // request decode; bit 27 takes no part so regions alias
  wire [2:0] cs_sel = sys_req_addr[`EBC_CS_MSB:`EBC_CS_LSB];
  wire [23:0] cs_off = sys_req_addr[23:0];
  wire [4:0] reg_sh = `EBC_BASE_LOG2 + {1'b0, eff_size[cs_sel]};
  wire in_region = (cs_off >> reg_sh) == 24'h0;
  wire sel_w8 = eff_w8[cs_sel];
  wire is_word = sys_req_size == ebc_pkg::EBC_SZ_WORD;
  wire is_half = sys_req_size == ebc_pkg::EBC_SZ_HALF;
  wire size_bad = (is_word && sys_req_write) || (is_half && sel_w8) ||
                  (sys_req_size == 2'h3);
  wire req_bad = !eff_ok[cs_sel] || !in_region || size_bad;
  wire [2:0] beats = is_word ? (sel_w8 ? 3'h4 : 3'h2) : 3'h1;
  wire accept = sys_req_valid && sys_req_ready;

  ebc_pkg::ebc_req_t req_nxt;
  assign req_nxt.addr = cs_off;
  assign req_nxt.cs = cs_sel;
  assign req_nxt.wr = sys_req_write;
  assign req_nxt.wdata = sys_req_wdata[15:0];
  assign req_nxt.beats = beats;
  assign req_nxt.w8 = sel_w8;
  assign req_nxt.mux = eff_mux[cs_sel];
  assign req_nxt.sty = eff_sty[cs_sel];
  assign req_nxt.ext = eff_ext[cs_sel];
  assign req_nxt.strb = eff_strb[cs_sel];

  // nothing is taken before the straps have fixed the boot width
  assign sys_req_ready = (cst_r == ebc_pkg::EBC_C_IDLE) && strap_ok_r;
  assign sys_resp_valid = cst_r == ebc_pkg::EBC_C_RESP;
  assign sys_resp_rdata = rdata_r;
  assign sys_resp_err = err_r;
  assign req_ev.tgl = req_tgl_r;

  // core side: q_r stays put until the far side toggles back
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cst_r <= ebc_pkg::EBC_C_IDLE;
      q_r <= '0;
      req_tgl_r <= 1'b0;
      err_r <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      case (cst_r)
        ebc_pkg::EBC_C_IDLE: begin
          if (accept) begin
            err_r <= req_bad;
            rdata_r <= 32'h0;
            if (req_bad) begin
              cst_r <= ebc_pkg::EBC_C_RESP;
            end else begin
              q_r <= req_nxt;
              req_tgl_r <= !req_tgl_r;
              cst_r <= ebc_pkg::EBC_C_BUSY;
            end
          end
        end
        ebc_pkg::EBC_C_BUSY: begin
          if (ack_ev.pulse) begin
            rdata_r <= acc_r;
            cst_r <= ebc_pkg::EBC_C_RESP;
          end
        end
        default: cst_r <= ebc_pkg::EBC_C_IDLE;
      endcase
    end
  end

  // exported settings; strap word is quiet once its flag has crossed
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_core_r <= 24'h0;
      strap_ok_r <= 1'b0;
      low_map_r <= `EBC_LOW_MAP_RST;
      sw_irq_r <= 2'h0;
    end else begin
      if (strap_ev.pulse) begin
        strap_core_r <= strap_r;
        strap_ok_r <= 1'b1;
      end
      if (low_map_wr) begin
        low_map_r <= low_map_val;
      end
      sw_irq_r <= sw_irq_in;
    end
  end

  assign cfg_strap_word = strap_core_r;
  assign cfg_strap_valid = strap_ok_r;
  assign cfg_low_map = low_map_r;
  assign cfg_pci_host = strap_core_r[`EBC_STRAP_PCI_HOST_BIT];
  assign cfg_pci_arbiter = strap_core_r[`EBC_STRAP_PCI_ARB_BIT];
  assign cfg_sw_irq = sw_irq_r;

  // external clock domain
  logic xr1_r;
  logic ext_rst_n;
  logic [23:0] as1_r;
  logic [23:0] as2_r;
  logic [15:0] ds1_r;
  logic [15:0] ds2_r;
  logic ws1_r;
  logic ws2_r;
  logic [3:0] rs1_r;
  logic [3:0] rs2_r;
  logic [1:0] settle_r;
  logic strap_done_r;
  logic strap_tgl_r;
  ebc_pkg::ebc_xstate_t xst_r;
  logic [3:0] cnt_r;
  logic [2:0] beat_r;
  logic [23:0] xaddr_r;
  logic ack_tgl_r;

  // reset asserts at once, leaves in step with the external clock
  always_ff @(posedge ext_bus_clock_in or negedge rst_n) begin
    if (!rst_n) begin
      xr1_r <= 1'b0;
      ext_rst_n <= 1'b0;
    end else begin
      xr1_r <= 1'b1;
      ext_rst_n <= xr1_r;
    end
  end

  // pin synchronisers, active-low wait and ready taken every edge
  always_ff @(posedge ext_bus_clock_in or negedge ext_rst_n) begin
    if (!ext_rst_n) begin
      as1_r <= 24'h0;
      as2_r <= 24'h0;
      ds1_r <= 16'h0;
      ds2_r <= 16'h0;
      ws1_r <= 1'b1;
      ws2_r <= 1'b1;
      rs1_r <= 4'hf;
      rs2_r <= 4'hf;
    end else begin
      as1_r <= ext_addr_in;
      as2_r <= as1_r;
      ds1_r <= ext_data_in;
      ds2_r <= ds1_r;
      ws1_r <= shared_wait_n;
      ws2_r <= ws1_r;
      rs1_r <= hostport_ready_n;
      rs2_r <= rs1_r;
    end
  end

  // straps: wait until the synchronisers hold real pin levels
  always_ff @(posedge ext_bus_clock_in or negedge ext_rst_n) begin
    if (!ext_rst_n) begin
      settle_r <= 2'h0;
      strap_done_r <= 1'b0;
      strap_tgl_r <= 1'b0;
      strap_r <= 24'h0;
    end else if (!strap_done_r) begin
      settle_r <= settle_r + 2'h1;
      if (settle_r == `EBC_STRAP_SETTLE) begin
        strap_r <= as2_r;
        strap_done_r <= 1'b1;
        strap_tgl_r <= 1'b1;
      end
    end
  end

  assign strap_ev.tgl = strap_tgl_r;
  assign ack_ev.tgl = ack_tgl_r;

  // transfer sequencing decode
  wire is_hp = q_r.sty == ebc_pkg::EBC_STY_HPORT;
  wire hp_ok = !rs2_r[q_r.cs[1:0]];
  wire rdy_ok = is_hp ? hp_ok : (q_r.wr || ws2_r);
  wire [3:0] addr_len = (q_r.mux ? `EBC_MUX_ADDR_CYC : `EBC_NMUX_ADDR_CYC)
                        + {2'h0, q_r.ext};
  wire [3:0] strb_ld = (q_r.strb == 4'h0) ? 4'h0 : q_r.strb - 4'h1;
  wire [23:0] xstep = q_r.w8 ? 24'h1 : 24'h2;
  wire [31:0] acc_nxt = q_r.w8 ? {acc_r[23:0], ds2_r[7:0]} :
                        {acc_r[15:0], ds2_r};
  wire in_addr = xst_r == ebc_pkg::EBC_X_ADDR;
  wire in_strb = xst_r == ebc_pkg::EBC_X_STRB;

  // one beat: address, strobe until count and ready, one hold clock
  always_ff @(posedge ext_bus_clock_in or negedge ext_rst_n) begin
    if (!ext_rst_n) begin
      xst_r <= ebc_pkg::EBC_X_IDLE;
      cnt_r <= 4'h0;
      beat_r <= 3'h0;
      xaddr_r <= 24'h0;
      acc_r <= 32'h0;
      ack_tgl_r <= 1'b0;
    end else begin
      case (xst_r)
        ebc_pkg::EBC_X_IDLE: begin
          if (req_ev.pulse) begin
            xaddr_r <= q_r.addr;
            beat_r <= q_r.beats;
            acc_r <= 32'h0;
            cnt_r <= addr_len - 4'h1;
            xst_r <= ebc_pkg::EBC_X_ADDR;
          end
        end
        ebc_pkg::EBC_X_ADDR: begin
          cnt_r <= cnt_r - 4'h1;
          if (cnt_r == 4'h0) begin
            cnt_r <= strb_ld;
            xst_r <= ebc_pkg::EBC_X_STRB;
          end
        end
        ebc_pkg::EBC_X_STRB: begin
          if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
          end else if (rdy_ok) begin
            if (!q_r.wr) begin
              acc_r <= acc_nxt;
            end
            xst_r <= ebc_pkg::EBC_X_HOLD;
          end
        end
        ebc_pkg::EBC_X_HOLD: begin
          beat_r <= beat_r - 3'h1;
          if (beat_r == 3'h1) begin
            ack_tgl_r <= !ack_tgl_r;
            xst_r <= ebc_pkg::EBC_X_IDLE;
          end else begin
            xaddr_r <= xaddr_r + xstep;
            cnt_r <= addr_len - 4'h1;
            xst_r <= ebc_pkg::EBC_X_ADDR;
          end
        end
        default: xst_r <= ebc_pkg::EBC_X_IDLE;
      endcase
    end
  end

  // pin values, registered one clock behind the state
  wire active = xst_r != ebc_pkg::EBC_X_IDLE;
  wire ds_sty = q_r.sty == ebc_pkg::EBC_STY_DSTRB;
  wire wr_n_nxt = ds_sty ? !in_strb : !(in_strb && q_r.wr);
  wire rd_n_nxt = ds_sty ? !(active && q_r.wr) :
                  !(in_strb && !q_r.wr);
  wire dout_oe_nxt = (q_r.mux && in_addr) || (q_r.wr && !in_addr && active);
  wire [15:0] dout_nxt = in_addr ? xaddr_r[15:0] : q_r.wdata;
  wire [7:0] cs_n_nxt = active ? ~(8'h1 << q_r.cs) : 8'hff;

  always_ff @(posedge ext_bus_clock_in or negedge ext_rst_n) begin
    if (!ext_rst_n) begin
      ext_cs_n <= 8'hff;
      addr_latch_strobe <= 1'b0;
      write_strobe_n <= 1'b1;
      read_strobe_n <= 1'b1;
      ext_data_oe <= 1'b0;
      ext_data_out <= 16'h0;
      ext_addr_out <= 24'h0;
      ext_addr_oe <= 1'b0;
    end else begin
      ext_cs_n <= cs_n_nxt;
      addr_latch_strobe <= in_addr;
      write_strobe_n <= wr_n_nxt;
      read_strobe_n <= rd_n_nxt;
      ext_data_oe <= dout_oe_nxt;
      ext_data_out <= dout_nxt;
      ext_addr_out <= xaddr_r;
      ext_addr_oe <= strap_done_r;
    end
  end

  ebc_evt_sync u_req_sync (
    .clk(ext_bus_clock_in),
    .rst_n(ext_rst_n),
    .ev(req_ev)
  );
  ebc_evt_sync u_ack_sync (
    .clk(core_clk),
    .rst_n(rst_n),
    .ev(ack_ev)
  );
  ebc_evt_sync u_strap_sync (
    .clk(core_clk),
    .rst_n(rst_n),
    .ev(strap_ev)
  );

  // helper: clocks spent in the address phase
  logic [3:0] alen_r;
  always_ff @(posedge ext_bus_clock_in or negedge ext_rst_n) begin
    if (!ext_rst_n) begin
      alen_r <= 4'h0;
    end else begin
      alen_r <= in_addr ? alen_r + 4'h1 : 4'h0;
    end
  end

  chk_cs_decode: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    accept && !req_bad |=> q_r.cs == $past(sys_req_addr[26:24]))
    else $error("chip select not from address bits 26:24");
  chk_addr_pass: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    accept && !req_bad |=> q_r.addr == $past(sys_req_addr[23:0]))
    else $error("low address bits altered");
  chk_unprog_err: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    accept && cs_sel != 3'h0 && !cs_programmed[cs_sel]
    |=> sys_resp_valid && sys_resp_err)
    else $error("unprogrammed select not refused");
  chk_word_write: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    accept && sys_req_write && is_word |=> sys_resp_valid && sys_resp_err)
    else $error("word write not refused");
  chk_region_err: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    accept && !in_region |=> sys_resp_err)
    else $error("access beyond region accepted");
  chk_boot_width: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    accept && !req_bad && cs_sel == 3'h0 && !cs_programmed[0]
    |=> q_r.w8 == !strap_core_r[`EBC_STRAP_W16_BIT])
    else $error("boot width not from strap");
  chk_addr_len: assert property (@(posedge ext_bus_clock_in)
    disable iff (!ext_rst_n)
    in_addr && cnt_r == 4'h0 |-> alen_r + 4'h1 == addr_len)
    else $error("address phase length wrong");
  chk_wait_hold: assert property (@(posedge ext_bus_clock_in)
    disable iff (!ext_rst_n)
    in_strb && !is_hp && !q_r.wr && !ws2_r |=> in_strb)
    else $error("read left strobe under wait");
  chk_hp_nowait: assert property (@(posedge ext_bus_clock_in)
    disable iff (!ext_rst_n)
    in_strb && is_hp && cnt_r == 4'h0 && hp_ok
    |=> xst_r == ebc_pkg::EBC_X_HOLD)
    else $error("host-port select held by wait");
  chk_addr_input: assert property (@(posedge ext_bus_clock_in)
    disable iff (!ext_rst_n)
    !strap_done_r |=> !ext_addr_oe)
    else $error("address driven before straps");
  chk_ds_style: assert property (@(posedge ext_bus_clock_in)
    disable iff (!ext_rst_n)
    in_strb && ds_sty |=> !write_strobe_n && read_strobe_n == !q_r.wr)
    else $error("data strobe style pins wrong");
endmodule

/* pkg/ebc_regs.svh */
`ifndef EBC_REGS_SVH
`define EBC_REGS_SVH
// external bus shape
`define EBC_NCS 8
`define EBC_ADDR_W 24
`define EBC_DATA_W 16
// system address decode: chip select field, bit 27 unused
`define EBC_CS_MSB 26
`define EBC_CS_LSB 24
// region size is 2**(base + size field)
`define EBC_BASE_LOG2 5'h09
// external clock ceiling, kHz, supplied by the system
`define EBC_EXT_CLK_MAX_KHZ 66660
// address phase length before extension
`define EBC_NMUX_ADDR_CYC 4'h1
`define EBC_MUX_ADDR_CYC 4'h2
// chip select 0 boot defaults: slow and wide open
`define EBC_CS0_EXT_RST 2'h3
`define EBC_CS0_STRB_RST 4'hf
`define EBC_CS0_SIZE_RST 4'hf
`define EBC_CS0_MUX_RST 1'b0
// strap bit positions in the captured address word
`define EBC_STRAP_W16_BIT 0
`define EBC_STRAP_PCI_HOST_BIT 1
`define EBC_STRAP_PCI_ARB_BIT 2
// settle cycles after reset release before the straps are taken
`define EBC_STRAP_SETTLE 2'h2
// low 256 Mbyte map goes to the expansion bus after reset
`define EBC_LOW_MAP_RST 1'b1
`endif

/* pkg/ebc_pkg.sv */
package ebc_pkg;
  typedef enum logic [1:0] {
    EBC_STY_RDWR = 2'h0,
    EBC_STY_DSTRB = 2'h1,
    EBC_STY_HPORT = 2'h2
  } ebc_style_t;
  typedef enum logic [1:0] {
    EBC_SZ_BYTE = 2'h0,
    EBC_SZ_HALF = 2'h1,
    EBC_SZ_WORD = 2'h2
  } ebc_size_t;
  typedef enum {EBC_C_IDLE, EBC_C_BUSY, EBC_C_RESP} ebc_cstate_t;
  typedef enum {EBC_X_IDLE, EBC_X_ADDR, EBC_X_STRB, EBC_X_HOLD} ebc_xstate_t;
  // one transfer as handed to the external clock domain
  typedef struct packed {
    logic [23:0] addr;
    logic [2:0] cs;
    logic wr;
    logic [15:0] wdata;
    logic [2:0] beats;
    logic w8;
    logic mux;
    logic [1:0] sty;
    logic [1:0] ext;
    logic [3:0] strb;
  } ebc_req_t;
endpackage

/* pkg/ebc_evt_if.sv */
`timescale 1ns/10ps
// toggle event between clock domains
interface ebc_evt_if;
  logic tgl;
  logic pulse;
  modport launch (output tgl);
  modport sync (input tgl, output pulse);
  modport land (input pulse);
endinterface

/* rtl/ebc_evt_sync.sv */
`timescale 1ns/10ps
module ebc_evt_sync (
  // destination clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // event carrier
  ebc_evt_if.sync ev
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // first flop feeds only the second; edges seen after that
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= ev.tgl;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign ev.pulse = s2_r ^ s3_r;
endmodule

/* verification/ebc_ext_dev.sv */
`timescale 1ns/10ps
// behavioural device on the expansion pins
module ebc_ext_dev (
  // clock and behaviour knobs
  input wire logic ext_bus_clock_in,
  input wire logic [23:0] strap,
  input wire logic [7:0] wait_len,
  input wire logic [7:0] rdy_len,
  input wire logic [1:0] hp_idx,
  // pins
  input wire logic [23:0] ext_addr_out,
  input wire logic ext_addr_oe,
  input wire logic [7:0] ext_cs_n,
  output logic [23:0] ext_addr_in,
  output logic [15:0] ext_data_in,
  output logic shared_wait_n,
  output logic [3:0] hostport_ready_n
);
  logic [7:0] wcnt = 8'h00;
  logic [7:0] rcnt = 8'h00;
  logic sel_d = 1'b0;
  wire sel = ~&ext_cs_n;
  wire start = sel && !sel_d;
  // pin level: controller when driving, else pull-ups and pull-downs
  assign ext_addr_in = ext_addr_oe ? ext_addr_out : strap;
  // hold-off ends a fixed count after the select falls
  assign shared_wait_n = (wcnt == 8'h00);
  // only the chosen ready line ever reports ready
  assign hostport_ready_n = ~((rcnt == 8'h00) ? 4'h1 << hp_idx : 4'h0);
  // data follows the address; toggles when not selected so no stale hit
  always @(posedge ext_bus_clock_in) begin
    sel_d <= sel;
    wcnt <= start ? wait_len : (wcnt != 8'h00) ? wcnt - 8'h01 : 8'h00;
    rcnt <= start ? rdy_len : (rcnt != 8'h00) ? rcnt - 8'h01 : 8'h00;
    ext_data_in <= sel ? {~ext_addr_out[7:0], ext_addr_out[7:0] ^ 8'h3c}
      : ~ext_data_in;
  end
  initial begin
    ext_data_in = 16'h0;
  end
endmodule

/* verification/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  // stimulus
  logic core_clk = 1'b0, ext_bus_clock_in = 1'b0, rst_n = 1'b0;
  logic sys_req_valid = 1'b0, sys_req_write = 1'b0;
  logic [27:0] sys_req_addr = 28'h0;
  logic [1:0] sys_req_size = 2'h0, sw_irq_in = 2'h0;
  logic [31:0] sys_req_wdata = 32'h0;
  logic [7:0] cs_programmed = 8'h26, cs_mux = 8'h02, cs_width8 = 8'h02;
  logic [15:0] cs_style = 16'h0824, cs_addr_phase_extend = 16'h0404;
  logic [31:0] cs_size = 32'h00f000f0, cs_strobe_cycles = 32'h00400440;
  logic low_map_wr = 1'b0, low_map_val = 1'b0;
  logic [7:0] wait_len = 8'h00, rdy_len = 8'h00;
  // observed
  logic sys_req_ready, sys_resp_valid, sys_resp_err, cfg_strap_valid;
  logic cfg_low_map, cfg_pci_host, cfg_pci_arbiter, ext_addr_oe, ext_data_oe;
  logic addr_latch_strobe, write_strobe_n, read_strobe_n, shared_wait_n;
  logic [31:0] sys_resp_rdata, d;
  logic [23:0] cfg_strap_word, ext_addr_in, ext_addr_out, la;
  logic [15:0] ext_data_in, ext_data_out, wd;
  logic [7:0] ext_cs_n, ale_n, csv;
  logic [3:0] hostport_ready_n;
  logic [1:0] cfg_sw_irq;
  logic ds_seen, rd_low, e, oe_seen;
  int num_errors = 0, n_tests = 0, cyc;
  realtime t0;

  ebc_ctrl dut_u (.core_clk, .rst_n, .ext_bus_clock_in, .sys_req_valid,
    .sys_req_ready, .sys_req_addr, .sys_req_write, .sys_req_size,
    .sys_req_wdata, .sys_resp_valid, .sys_resp_rdata, .sys_resp_err,
    .cs_programmed, .cs_style, .cs_addr_phase_extend, .cs_size,
    .cs_strobe_cycles, .cs_mux, .cs_width8, .low_map_wr, .low_map_val,
    .sw_irq_in, .cfg_strap_word, .cfg_strap_valid, .cfg_low_map,
    .cfg_pci_host, .cfg_pci_arbiter, .cfg_sw_irq, .ext_addr_in,
    .ext_addr_out, .ext_addr_oe, .ext_data_in, .ext_data_out, .ext_data_oe,
    .addr_latch_strobe, .ext_cs_n, .write_strobe_n, .read_strobe_n,
    .shared_wait_n, .hostport_ready_n);
  // board straps: bit 2 pulled down, the rest float high
  ebc_ext_dev dev_u (.ext_bus_clock_in, .strap(24'hfffffb), .wait_len,
    .rdy_len, .hp_idx(2'h1), .ext_addr_out, .ext_addr_oe, .ext_cs_n,
    .ext_addr_in, .ext_data_in, .shared_wait_n, .hostport_ready_n);

  // clocks; link edges offset so they never meet core edges
  initial forever #2 core_clk = ~core_clk;
  initial begin
    #1.3;
    forever #7.5 ext_bus_clock_in = ~ext_bus_clock_in;
  end
  // pin monitor on the link clock
  always @(posedge ext_bus_clock_in) begin
    if (!write_strobe_n) begin
      ds_seen <= 1'b1;
      wd <= ext_data_out;
    end
    if (!read_strobe_n) rd_low <= 1'b1;
    if (ext_data_oe) oe_seen <= 1'b1;
    if (addr_latch_strobe) begin
      ale_n <= ale_n + 8'h01;
      la <= ext_addr_out;
      csv <= ext_cs_n;
    end
  end

  function automatic logic [15:0] fw(input logic [23:0] a);
    return {~a[7:0], a[7:0] ^ 8'h3c};
  endfunction
  task chk(input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task clr;
    ds_seen = 1'b0;
    rd_low = 1'b0;
    oe_seen = 1'b0;
    ale_n = 8'h00;
  endtask
  // one request held until taken, then wait for its answer
  task acc(input logic [27:0] a, input logic w, input logic [1:0] sz,
    input logic [31:0] wv);
    int i;
    clr;
    @(posedge core_clk);
    sys_req_addr <= a;
    sys_req_write <= w;
    sys_req_size <= sz;
    sys_req_wdata <= wv;
    sys_req_valid <= 1'b1;
    i = 0;
    do begin
      @(negedge core_clk);
      i++;
    end while (sys_req_ready !== 1'b1 && i < 500);
    @(posedge core_clk);
    sys_req_valid <= 1'b0;
    cyc = 0;
    do begin
      @(negedge core_clk);
      cyc++;
    end while (sys_resp_valid !== 1'b1 && cyc < 5000);
    if (i >= 500 || cyc >= 5000) begin
      chk(32'h1, 32'h0);
      final_report;
    end
    d = sys_resp_rdata;
    e = sys_resp_err;
  endtask
  // refused request: error, zero data, answer on the next cycle
  task err_case(input logic [27:0] a, input logic w, input logic [1:0] sz);
    acc(a, w, sz, 32'hffffffff);
    chk(32'h1, {31'h0, e});
    chk(32'h0, d);
    chk(32'h1, cyc);
  endtask

  task t_straps;
    // output enable follows the strap flag by up to one link clock
    repeat (8) @(negedge core_clk);
    chk(32'hfffffb, {8'h0, cfg_strap_word});
    chk(32'h1, {31'h0, ext_addr_oe});
    chk(32'h1, {31'h0, cfg_pci_host});
    chk(32'h0, {31'h0, cfg_pci_arbiter});
    chk(32'h1, {31'h0, cfg_low_map});
    @(posedge core_clk);
    sw_irq_in <= 2'h2;
    low_map_wr <= 1'b1;
    @(posedge core_clk);
    low_map_wr <= 1'b0;
    @(negedge core_clk);
    chk(32'h2, {30'h0, cfg_sw_irq});
    chk(32'h0, {31'h0, cfg_low_map});
    $display("done: straps");
  endtask
  // boot select, wide strap: two halves, bit 27 aliased away
  task t_boot_read;
    acc(28'h8000010, 1'b0, 2'h2, 32'h0);
    chk({fw(24'h10), fw(24'h12)}, d);
    chk(32'h12, {8'h0, la});
    chk(32'h8, {24'h0, ale_n});
    chk(32'h1, {31'h0, rd_low});
    chk(32'h0, {31'h0, ds_seen});
    chk(32'h0, {31'h0, e});
    chk(32'h0, {31'h0, oe_seen});
    chk(32'hfe, {24'h0, csv});
    $display("done: boot read");
  endtask
  task t_errors;
    err_case(28'h3000000, 1'b0, 2'h0);
    err_case(28'h0000000, 1'b1, 2'h2);
    err_case(28'h0000000, 1'b0, 2'h3);
    err_case(28'h2000200, 1'b0, 2'h1);
    err_case(28'h1000100, 1'b0, 2'h1);
    acc(28'h20001fe, 1'b0, 2'h1, 32'h0);
    chk({16'h0, fw(24'h1fe)}, d);
    chk(32'h1, {31'h0, rd_low});
    $display("done: errors");
  endtask
  // 8-bit multiplexed data-strobe select with a long hold-off
  task t_narrow;
    wait_len = 8'h64;
    t0 = $realtime;
    acc(28'h1000100, 1'b0, 2'h2, 32'h0);
    chk(32'h3c3d3e3f, d);
    chk(32'h1, {31'h0, $realtime - t0 > 1500.0});
    chk(32'hc, {24'h0, ale_n});
    chk(32'h1, {31'h0, ds_seen});
    chk(32'h0, {31'h0, rd_low});
    chk(32'h1, {31'h0, oe_seen});
    wait_len = 8'h00;
    acc(28'h1000105, 1'b1, 2'h0, 32'h000000a5);
    chk(32'h0, {31'h0, e});
    chk(32'ha5, {24'h0, wd[7:0]});
    chk(32'h1, {31'h0, rd_low});
    chk(32'h3, {24'h0, ale_n});
    $display("done: narrow");
  endtask
  // host-port select: shared wait held, own ready decides
  task t_hostport;
    wait_len = 8'hff;
    rdy_len = 8'h10;
    t0 = $realtime;
    acc(28'h5000020, 1'b0, 2'h1, 32'h0);
    chk({16'h0, fw(24'h20)}, d);
    chk(32'h1, {31'h0, $realtime - t0 < 3000.0});
    chk(32'h1, {31'h0, $realtime - t0 > 240.0});
    chk(32'hdf, {24'h0, csv});
    $display("done: host port");
  endtask

  initial begin
    repeat (5) @(posedge core_clk);
    chk(32'h0, {31'h0, ext_addr_oe});
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 300 && cfg_strap_valid !== 1'b1; i++)
      @(negedge core_clk);
    chk(32'h1, {31'h0, cfg_strap_valid});
    if (cfg_strap_valid !== 1'b1) begin
      final_report;
    end
    t_straps;
    t_boot_read;
    t_errors;
    t_narrow;
    t_hostport;
    final_report;
  end
endmodule
